// ===== common/cmeo_pkg.sv
// Constants and types shared by the control-mode entry and OTP access block
package cmeo_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CMEO_CLK_PERIOD_NS = 10;      // 100 MHz system clock
    localparam int CMEO_RESET_HOLD_NS = 20000;   // 20 us internal reset interval
    // Least time, so round up to whole cycles
    localparam int CMEO_RESET_HOLD_INT =
        (CMEO_RESET_HOLD_NS + CMEO_CLK_PERIOD_NS - 1) / CMEO_CLK_PERIOD_NS;
    localparam logic [11:0] CMEO_RESET_HOLD_CYC = 12'(CMEO_RESET_HOLD_INT);
    localparam logic [3:0]  CMEO_ESCAPE_EDGES   = 4'hA;  // 10 crystal edges held high
    localparam logic [3:0]  CMEO_CODE_BITS_LAST = 4'h9;  // index of the tenth code bit
    localparam logic [3:0]  CMEO_TAIL_LAST      = 4'h8;  // ninth high edge after the code

    // ------------------------------------------------------------
    // Memory geometry and reset values
    // ------------------------------------------------------------
    localparam int          CMEO_PROG_BYTES  = 32768;
    localparam int          CMEO_ID_BYTES    = 384;
    localparam int          CMEO_ID_ADDR_W   = 5;    // only five low address lines reach the id area
    localparam logic [7:0]  CMEO_ERASED_BYTE = 8'hFF;

    // ------------------------------------------------------------
    // Mode codes, shifted most significant bit first
    // ------------------------------------------------------------
    localparam logic [9:0] CMEO_CODE_EMUL    = 10'h185;  // 0110000101
    localparam logic [9:0] CMEO_CODE_PROG    = 10'h105;  // 0100000101
    localparam logic [9:0] CMEO_CODE_PROG_ID = 10'h115;  // 0100010101
    localparam logic [9:0] CMEO_CODE_VERIFY  = 10'h1F5;  // 0111110101

    typedef enum logic [2:0] {
        CMEO_MODE_NORMAL  = 3'h0,
        CMEO_MODE_EMUL    = 3'h1,
        CMEO_MODE_PROG    = 3'h2,
        CMEO_MODE_PROG_ID = 3'h3,
        CMEO_MODE_VERIFY  = 3'h4
    } cmeo_mode_type;

    typedef enum logic [1:0] {
        CMEO_ST_RUN   = 2'h0,
        CMEO_ST_HOLD  = 2'h1,
        CMEO_ST_SHIFT = 2'h2,
        CMEO_ST_TAIL  = 2'h3
    } cmeo_state_type;

endpackage : cmeo_pkg

// ===== rtl/cmeo_store.sv
// Program store and identification area, flip-flop based
`timescale 1ns/10ps
module cmeo_store
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Write side
    input  wire logic        write_enable,
    input  wire logic        write_id,
    input  wire logic [14:0] write_address,
    input  wire logic [7:0]  write_data,
    // Read side
    input  wire logic [14:0] read_address,
    output logic      [7:0]  read_data
);
    import cmeo_pkg::*;

    logic [7:0] prog_mem [CMEO_PROG_BYTES];
    logic [7:0] id_mem   [CMEO_ID_BYTES];
    logic [8:0] id_index;

    // Only the lowest address lines select an id byte
    assign id_index = {4'h0, write_address[CMEO_ID_ADDR_W-1:0]};

    // ------------------------------------------------------------
    // Storage: one-time cells only clear bits, so writes AND in
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // Reset stands in for a blank part, which keeps simulation free of unknowns
            for (int i = 0; i < CMEO_PROG_BYTES; i++)
                prog_mem[i] <= CMEO_ERASED_BYTE;
            for (int j = 0; j < CMEO_ID_BYTES; j++)
                id_mem[j] <= CMEO_ERASED_BYTE;
            read_data <= 8'h00;
        end
        else if (ce)
        begin
            if (write_enable && write_id)
                id_mem[id_index] <= id_mem[id_index] & write_data;
            else if (write_enable)
                prog_mem[write_address] <= prog_mem[write_address] & write_data;
            read_data <= prog_mem[read_address];
        end
    end

endmodule : cmeo_store

// ===== rtl/cmeo_top.sv
// Control-mode entry by serial code on the reset pin, and OTP programming access
`timescale 1ns/10ps

// What this block does
// - Mode code shifts into reset, crystal clocks
// - Start zero, five mode bits, trailer 0101
// - Held high, no code: normal mode
// - Reset pin sampled on crystal rising edges
// - Code MSB first; emulation is 0110000101
// - No low within nine edges: normal
// - Decode program, id-area, verify codes
// - Id area addressed by five low lines
// - Execute only in normal mode
module cmeo_top
(
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Mode entry pins
    input  wire logic                 crystal_clock_input,
    input  wire logic                 reset_pin,
    // Programming pins
    input  wire logic [14:0]          program_address_lines,
    input  wire logic [7:0]           program_write_bytes,
    input  wire logic                 write_strobe_n,
    input  wire logic                 output_enable_n,
    output logic      [7:0]           verify_read_bytes,
    output logic                      verify_read_oe,
    // Core fetch port
    input  wire logic [14:0]          fetch_address,
    output logic      [7:0]           fetch_data,
    output logic                      fetch_allowed,
    // Mode status
    output cmeo_pkg::cmeo_mode_type   control_mode
);
    import cmeo_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [27:0]    sync1;       // first synchroniser stage, read only by sync2
        logic [27:0]    sync2;
        logic           crys_prev;
        logic           we_prev;
        cmeo_state_type state;
        cmeo_mode_type  mode;
        logic [9:0]     shreg;
        logic [3:0]     bitcnt;
        logic [3:0]     edgecnt;
        logic [11:0]    timecnt;
        logic           oe;
    } cmeo_regs_type;

    cmeo_regs_type r_reg;
    cmeo_regs_type r_next;

    logic        crys_s;
    logic        rpin_s;
    logic        we_s;
    logic        oe_s;
    logic [14:0] addr_s;
    logic [7:0]  din_s;
    logic        crys_rise;
    logic        armed;
    logic        store_we;
    logic        store_id;
    logic [14:0] store_raddr;
    logic [7:0]  store_rdata;

    // ------------------------------------------------------------
    // Code decoder: anything unlisted, test codes included, is normal
    // ------------------------------------------------------------
    function automatic cmeo_mode_type decode_code(input logic [9:0] code);
        cmeo_mode_type m;
        case (code)
            CMEO_CODE_EMUL:    m = CMEO_MODE_EMUL;
            CMEO_CODE_PROG:    m = CMEO_MODE_PROG;
            CMEO_CODE_PROG_ID: m = CMEO_MODE_PROG_ID;
            CMEO_CODE_VERIFY:  m = CMEO_MODE_VERIFY;
            default:           m = CMEO_MODE_NORMAL;
        endcase
        return m;
    endfunction : decode_code

    // Synchronised pin views (second stage only)
    assign crys_s = r_reg.sync2[27];
    assign rpin_s = r_reg.sync2[26];
    assign we_s   = r_reg.sync2[25];
    assign oe_s   = r_reg.sync2[24];
    assign addr_s = r_reg.sync2[23:9];
    assign din_s  = r_reg.sync2[8:1];

    // Crystal rising edge, seen after synchronising, paces the shifter
    assign crys_rise = crys_s & ~r_reg.crys_prev;
    assign armed     = (r_reg.edgecnt >= CMEO_ESCAPE_EDGES) && (r_reg.timecnt >= CMEO_RESET_HOLD_CYC);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        r_next           = r_reg;
        r_next.sync1     = {crystal_clock_input, reset_pin, write_strobe_n, output_enable_n,
                            program_address_lines, program_write_bytes, 1'b0};
        r_next.sync2     = r_reg.sync1;
        r_next.crys_prev = crys_s;
        r_next.we_prev   = we_s;
        store_we         = 1'b0;
        store_id         = 1'b0;

        case (r_reg.state)
            CMEO_ST_RUN:
            begin
                // A high reset level on a crystal edge starts a new entry sequence
                if (crys_rise && rpin_s)
                begin
                    r_next.state   = CMEO_ST_HOLD;
                    r_next.edgecnt = 4'h1;
                    r_next.timecnt = 12'h000;
                end
            end
            CMEO_ST_HOLD:
            begin
                if (r_reg.timecnt < CMEO_RESET_HOLD_CYC)
                    r_next.timecnt = r_reg.timecnt + 12'h001;
                if (r_reg.edgecnt >= CMEO_ESCAPE_EDGES)
                    r_next.mode = CMEO_MODE_NORMAL;  // Long enough high escapes any mode
                if (crys_rise)
                begin
                    if (rpin_s)
                    begin
                        if (r_reg.edgecnt < CMEO_ESCAPE_EDGES)
                            r_next.edgecnt = r_reg.edgecnt + 4'h1;
                    end
                    else if (armed)
                    begin
                        // First low is the start bit; normal runs unless a code lands
                        r_next.mode   = CMEO_MODE_NORMAL;
                        r_next.state  = CMEO_ST_SHIFT;
                        r_next.shreg  = {9'h000, rpin_s};
                        r_next.bitcnt = 4'h1;
                    end
                    else
                    begin
                        // Too short a pulse: the old mode stays unless ten high edges already forced normal
                        r_next.state = CMEO_ST_RUN;
                    end
                end
            end
            CMEO_ST_SHIFT:
            begin
                if (crys_rise)
                begin
                    r_next.shreg  = {r_reg.shreg[8:0], rpin_s};
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    if (r_reg.bitcnt == CMEO_CODE_BITS_LAST)
                    begin
                        r_next.state   = CMEO_ST_TAIL;
                        r_next.edgecnt = 4'h0;
                    end
                end
            end
            CMEO_ST_TAIL:
            begin
                if (crys_rise)
                begin
                    if (!rpin_s)
                    begin
                        r_next.mode  = decode_code(r_reg.shreg);
                        r_next.state = CMEO_ST_RUN;
                    end
                    else if (r_reg.edgecnt == CMEO_TAIL_LAST)
                    begin
                        // Reset stayed high too long: fall back, treat as fresh hold
                        r_next.mode    = CMEO_MODE_NORMAL;
                        r_next.state   = CMEO_ST_HOLD;
                        r_next.edgecnt = 4'h1;
                        r_next.timecnt = 12'h000;
                    end
                    else
                        r_next.edgecnt = r_reg.edgecnt + 4'h1;
                end
            end
            default:
            begin
                r_next.state = CMEO_ST_RUN;
            end
        endcase

        // Byte is committed when the active-low write strobe returns high
        if (r_reg.state == CMEO_ST_RUN && we_s && !r_reg.we_prev)
        begin
            store_we = (r_reg.mode == CMEO_MODE_PROG) || (r_reg.mode == CMEO_MODE_PROG_ID);
            store_id = (r_reg.mode == CMEO_MODE_PROG_ID);
        end

        // Data pins driven only in verify mode with output enable low
        r_next.oe = (r_reg.state == CMEO_ST_RUN) && (r_reg.mode == CMEO_MODE_VERIFY) && !oe_s;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_reg           <= '0;
            r_reg.state     <= CMEO_ST_RUN;
            r_reg.mode      <= CMEO_MODE_NORMAL;
            // Crystal and strobes idle high; starting them low would fake an edge after reset
            r_reg.sync1[27] <= 1'b1;
            r_reg.sync1[25] <= 1'b1;
            r_reg.sync1[24] <= 1'b1;
            r_reg.sync2[27] <= 1'b1;
            r_reg.sync2[25] <= 1'b1;
            r_reg.sync2[24] <= 1'b1;
            r_reg.crys_prev <= 1'b1;
            r_reg.we_prev   <= 1'b1;
        end
        else if (ce)
            r_reg <= r_next;
    end

    // Verify reads follow the pins, otherwise the core fetch address
    assign store_raddr = (r_reg.mode == CMEO_MODE_VERIFY) ? addr_s : fetch_address;

    // ------------------------------------------------------------
    // Memory
    // ------------------------------------------------------------
    cmeo_store u_store
    (
        .clk           (clk),
        .rst           (rst),
        .ce            (ce),
        .write_enable  (store_we),
        .write_id      (store_id),
        .write_address (addr_s),
        .write_data    (din_s),
        .read_address  (store_raddr),
        .read_data     (store_rdata)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign verify_read_bytes = store_rdata;
    assign verify_read_oe    = r_reg.oe;
    assign fetch_data        = store_rdata;
    // Execution is gated off during entry and in all special modes
    assign fetch_allowed     = (r_reg.mode == CMEO_MODE_NORMAL) && (r_reg.state == CMEO_ST_RUN);
    assign control_mode      = r_reg.mode;

endmodule : cmeo_top

// ===== verif/cmeo_top_asserts.sv
// Port-level checker for the control-mode entry and OTP access block
`timescale 1ns/10ps
module cmeo_top_asserts
    import cmeo_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    // Pins and status
    input wire logic        crystal_clock_input,
    input wire logic [14:0] program_address_lines,
    input wire logic        output_enable_n,
    input wire logic [7:0]  verify_read_bytes,
    input wire logic        verify_read_oe,
    input wire logic        fetch_allowed,
    input cmeo_mode_type    control_mode
);
    // ------------------------------------------------------------
    // Properties, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RST_NORMAL: assert property (disable iff (1'b0) rst && ce |=> control_mode == CMEO_MODE_NORMAL && fetch_allowed && !verify_read_oe)
        else $error("state after reset not normal");
    AST_FETCH_NORMAL: assert property (fetch_allowed |-> control_mode == CMEO_MODE_NORMAL)
        else $error("fetch allowed outside normal mode");
    AST_OE_VERIFY: assert property (verify_read_oe |-> control_mode == CMEO_MODE_VERIFY)
        else $error("data lines driven outside verify mode");
    AST_OE_RISE: assert property ((control_mode == CMEO_MODE_VERIFY && !output_enable_n) [*6] |-> verify_read_oe)
        else $error("data lines not driven during read strobe");
    AST_OE_DROP: assert property (output_enable_n [*6] |-> !verify_read_oe)
        else $error("data lines still driven after read strobe");
    // Latency from a crystal edge to a mode change is a few cycles, so a quiet crystal freezes the mode
    AST_MODE_QUIET: assert property ($stable(crystal_clock_input) [*8] |=> $stable(control_mode))
        else $error("mode changed without a crystal edge");
    AST_VERIFY_HOLD: assert property ((control_mode == CMEO_MODE_VERIFY && $stable(program_address_lines) && $stable(output_enable_n)) [*8] |=> $stable(verify_read_bytes))
        else $error("read byte moved with address held");
    AST_MODE_LEGAL: assert property (control_mode inside {[CMEO_MODE_NORMAL:CMEO_MODE_VERIFY]})
        else $error("mode outside the defined set");

    // Main scenarios
    cover property (control_mode == CMEO_MODE_EMUL);
    cover property (verify_read_oe);
    cover property ($fell(control_mode == CMEO_MODE_PROG));
endmodule : cmeo_top_asserts

bind cmeo_top cmeo_top_asserts cmeo_top_asserts_inst (.clk, .rst, .ce, .crystal_clock_input,
    .program_address_lines, .output_enable_n, .verify_read_bytes, .verify_read_oe, .fetch_allowed, .control_mode);

// ===== verif/cmeo_prog_model.sv
// Programmer model: shifts mode codes, pulses writes and strobes reads
`timescale 1ns/10ps
module cmeo_prog_model
(
    // Clock
    input  wire logic        clk,
    // Device answers
    input  wire logic [7:0]  verify_read_bytes,
    input  wire logic        verify_read_oe,
    // Pins toward the device
    output logic             crystal_clock_input,
    output logic             reset_pin,
    output logic      [14:0] program_address_lines,
    output logic      [7:0]  program_write_bytes,
    output logic             write_strobe_n,
    output logic             output_enable_n
);
    localparam int HOLD_CYC  = 2100;  // Internal reset interval plus margin
    localparam int PULSE_CYC = 9000;  // Shortest legal write pulse

    // Idle pins at time zero
    initial
    begin
        crystal_clock_input   = 1'b1;
        reset_pin             = 1'b1;
        program_address_lines = 15'h0000;
        program_write_bytes   = 8'hFF;
        write_strobe_n        = 1'b1;
        output_enable_n       = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    // Reset changes while the crystal is low, giving wide setup and hold
    task automatic xedge(input logic lvl);
        crystal_clock_input <= 1'b0;
        reset_pin           <= lvl;
        wait_clk(4);
        crystal_clock_input <= 1'b1;
        wait_clk(4);
    endtask : xedge

    task automatic enter(input logic [9:0] code, input int tail);
        repeat (10) xedge(1'b1);
        wait_clk(HOLD_CYC);
        for (int i = 9; i >= 0; i--)
            xedge(code[i]);
        repeat (tail) xedge(1'b1);
        xedge(1'b0);
        wait_clk(8);
    endtask : enter

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        program_address_lines <= a;
        program_write_bytes   <= d;
        wait_clk(200);
        write_strobe_n <= 1'b0;
        wait_clk(PULSE_CYC);
        write_strobe_n <= 1'b1;
        wait_clk(2000);
        program_write_bytes <= ~d; // Hold over: lines stop carrying the byte
        wait_clk(1); // Keeps a following write from driving the data lines in the same step
    endtask : wr

    task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic o);
        program_address_lines <= a;
        output_enable_n       <= 1'b0;
        wait_clk(40);
        d = verify_read_bytes;
        o = verify_read_oe;
        output_enable_n <= 1'b1;
        wait_clk(10);
    endtask : rd
endmodule : cmeo_prog_model

// ===== verif/cmeo_top_tb.sv
// Self-checking bench for control-mode entry and OTP access
`timescale 1ns/10ps
module cmeo_top_tb;
    import cmeo_pkg::*;
    logic          clk, rst, ce, xtal, rpin, we_n, oe_n, v_oe, f_ok;
    logic [14:0]   addr, f_addr;
    logic [7:0]    wdat, vdat, f_dat;
    logic [31:0]   seed;
    cmeo_mode_type mode;
    int            bad_count, total_checks;

    cmeo_top cmeo_top_inst (.clk(clk), .rst(rst), .ce(ce), .crystal_clock_input(xtal), .reset_pin(rpin),
        .program_address_lines(addr), .program_write_bytes(wdat), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .verify_read_bytes(vdat), .verify_read_oe(v_oe),
        .fetch_address(f_addr), .fetch_data(f_dat), .fetch_allowed(f_ok), .control_mode(mode));
    cmeo_prog_model cmeo_prog_model_inst (.clk(clk), .verify_read_bytes(vdat), .verify_read_oe(v_oe),
        .crystal_clock_input(xtal), .reset_pin(rpin), .program_address_lines(addr),
        .program_write_bytes(wdat), .write_strobe_n(we_n), .output_enable_n(oe_n));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic cmeo_mode_type exp_mode(input logic [9:0] c);
        case (c)
            10'b0110000101: return CMEO_MODE_EMUL;
            10'b0100000101: return CMEO_MODE_PROG;
            10'b0100010101: return CMEO_MODE_PROG_ID;
            10'b0111110101: return CMEO_MODE_VERIFY;
            default:        return CMEO_MODE_NORMAL;
        endcase
    endfunction : exp_mode

    task automatic chk_val(input string what, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk_val

    task automatic chk_mode(input cmeo_mode_type e);
        chk_val("control_mode", {5'h00, e}, {5'h00, mode});
        chk_val("fetch_allowed", {7'h00, e == CMEO_MODE_NORMAL}, {7'h00, f_ok});
    endtask : chk_mode

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // Hang guard, well beyond the expected run
    initial
    begin
        repeat (95000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial
    begin
        logic [9:0]  c [6];
        logic [14:0] a [3];
        logic [7:0]  v [3];
        logic [7:0]  d;
        logic        o;
        rst = 1'b1;
        ce = 1'b1;
        f_addr = 15'h0000;
        seed = 32'h86F4;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_mode(CMEO_MODE_NORMAL);
        // Every code, a plain boot and a random code; tail length walks up to the last legal edge
        seed = xs(seed);
        // The random code keeps its start bit at zero, as the programmer must send it
        c = '{10'b0110000101, 10'b0100000101, 10'b0100010101, 10'b0111110101, 10'h000, {1'b0, seed[8:0]}};
        foreach (c[i])
        begin
            cmeo_prog_model_inst.enter(c[i], i + 3);
            chk_mode(exp_mode(c[i]));
        end
        cmeo_prog_model_inst.enter(10'b0100000101, 9);
        chk_mode(CMEO_MODE_NORMAL);
        // Two program writes, one of them all zero, upper bits keep addresses apart
        cmeo_prog_model_inst.enter(10'b0100000101, 0);
        for (int k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            a[k] = {k[1:0], seed[12:0]};
            v[k] = (k == 0) ? 8'h00 : seed[23:16];
            if (k < 2)
                cmeo_prog_model_inst.wr(a[k], v[k]);
        end
        // Id write must not reach the program store
        cmeo_prog_model_inst.enter(10'b0100010101, 0);
        cmeo_prog_model_inst.wr(a[2], 8'h00);
        cmeo_prog_model_inst.enter(10'b0111110101, 0);
        cmeo_prog_model_inst.wr(a[1], 8'h00);
        v[2] = 8'hFF;
        for (int k = 0; k < 3; k++)
        begin
            cmeo_prog_model_inst.rd(a[k], d, o);
            chk_val("verify_read_oe", 8'h01, {7'h00, o});
            chk_val("verify_read_bytes", v[k], d);
        end
        // Normal mode: no drive on read, program fetched from the store
        cmeo_prog_model_inst.enter(10'h000, 0);
        cmeo_prog_model_inst.rd(a[1], d, o);
        chk_val("verify_read_oe", 8'h00, {7'h00, o});
        f_addr <= a[1];
        repeat (2) @(posedge clk);
        chk_val("fetch_data", v[1], f_dat);
        wrap_up();
    end
endmodule : cmeo_top_tb
